/* File: rrs_exec.sv */
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Return pops stack top into PC, takes two cycles, flags untouched.
// - Left rotate shifts file register toward MSB through carry.
// - Left rotate destination 0 writes W, 1 writes the file register.
// - Sleep clears power-down flag and sets timeout flag.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep enters low-power state and stops the oscillator.
// - Right rotate shifts file register toward LSB through carry.
// - Right rotate destination 0 writes W, 1 writes the file register.
module rrs_exec
  import rrs_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS = 128
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic wdt_clear,
  output logic osc_enable,
  output logic sleep_state
);
  localparam int SPW = $clog2(STACK_DEPTH);

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  rrs_state_t state, next_state;
  logic [7:0] w, next_w;
  logic carry, next_carry;
  logic timeout_flag, next_timeout_flag;
  logic power_down_flag, next_power_down_flag;
  logic [12:0] pc, next_pc;
  logic [SPW-1:0] sp, next_sp;
  logic [6:0] faddr, next_faddr;
  logic next_wdt_clear;
  logic ack, next_ack;
  logic [31:0] next_readdata;
  logic [12:0] stack [STACK_DEPTH];
  logic [7:0] fmem [FILE_WORDS];
  logic stk_we;
  logic [SPW-1:0] stk_wa;
  logic [12:0] stk_wd;
  logic f_we;
  logic [6:0] f_wa;
  logic [7:0] f_wd;
  logic [12:0] stack_top_entry;
  logic [7:0] fsrc;
  logic req, take, wr_take, cmd_stall;
  rrs_cmd_t cmd;

  assign stack_top_entry = stack[sp - SPW'(1)];
  assign cmd = rrs_cmd_t'(writedata[RRS_CMD_D_BIT:RRS_CMD_OP_LSB]);
  assign fsrc = fmem[cmd.faddr];
  assign osc_enable = (state != RRS_ST_SLEEP);
  assign sleep_state = (state == RRS_ST_SLEEP);

  // ----------------------------------------
  // Avalon slave handshake
  // ----------------------------------------
  // Command writes stall only during the second return cycle
  assign cmd_stall = write && address == RRS_CMD_OFS && state == RRS_ST_RET2;
  assign req = read | write;
  assign waitrequest = req & ~ack;
  assign take = req & ack;
  assign wr_take = take & write & byteenable[0];

  always_comb begin
    next_ack = req & ~ack & ~cmd_stall;
    next_readdata = readdata;
    if (req && !ack && read) begin
      next_readdata = 32'h0000_0000;
      case (address)
        RRS_CMD_OFS: next_readdata[RRS_ST_BUSY_BIT] = (state == RRS_ST_RET2);
        RRS_W_OFS: next_readdata[7:0] = w;
        RRS_STAT_OFS: begin
          next_readdata[RRS_ST_C_BIT] = carry;
          next_readdata[RRS_ST_TIMEOUT_BIT] = timeout_flag;
          next_readdata[RRS_ST_PWRDN_BIT] = power_down_flag;
          next_readdata[RRS_ST_SLP_BIT] = sleep_state;
          next_readdata[RRS_ST_BUSY_BIT] = (state == RRS_ST_RET2);
        end
        RRS_PC_OFS: next_readdata[12:0] = pc;
        RRS_FADDR_OFS: next_readdata[6:0] = faddr;
        RRS_FDATA_OFS: next_readdata[7:0] = fmem[faddr];
        RRS_STACK_OFS: next_readdata[12:0] = stack_top_entry;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Execution and register writes
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_w = w;
    next_carry = carry;
    next_timeout_flag = timeout_flag;
    next_power_down_flag = power_down_flag;
    next_pc = pc;
    next_sp = sp;
    next_faddr = faddr;
    next_wdt_clear = 1'b0;
    stk_we = 1'b0;
    stk_wa = sp;
    stk_wd = writedata[12:0];
    f_we = 1'b0;
    f_wa = faddr;
    f_wd = writedata[7:0];
    case (state)
      RRS_ST_IDLE: begin
        if (wr_take && address == RRS_CMD_OFS) begin
          case (cmd.op)
            RRS_OP_RETURN: begin
              next_pc = stack_top_entry;
              next_sp = sp - SPW'(1);
              next_state = RRS_ST_RET2;
            end
            RRS_OP_ROTL, RRS_OP_ROTR: begin
              // Only carry among the flags moves
              if (cmd.op == RRS_OP_ROTL) begin
                f_wd = {fsrc[6:0], carry};
                next_carry = fsrc[7];
              end else begin
                f_wd = {carry, fsrc[7:1]};
                next_carry = fsrc[0];
              end
              if (cmd.dest_file) begin
                f_we = 1'b1;
                f_wa = cmd.faddr;
              end else begin
                next_w = f_wd;
              end
            end
            RRS_OP_SLEEP: begin
              next_power_down_flag = 1'b0;
              next_timeout_flag = 1'b1;
              next_wdt_clear = 1'b1;
              next_state = RRS_ST_SLEEP;
            end
            default: next_state = RRS_ST_IDLE;
          endcase
        end
      end
      RRS_ST_RET2: next_state = RRS_ST_IDLE;
      RRS_ST_SLEEP: begin
        // Wake-up cause is outside this block; software write stands in
        if (wr_take && address == RRS_WAKE_OFS) begin
          next_state = RRS_ST_IDLE;
        end
      end
      default: next_state = RRS_ST_IDLE;
    endcase
    if (wr_take) begin
      case (address)
        RRS_W_OFS: next_w = writedata[7:0];
        RRS_STAT_OFS: next_carry = writedata[RRS_ST_C_BIT];
        RRS_PC_OFS: begin
          next_pc[7:0] = writedata[7:0];
          if (byteenable[1]) begin
            next_pc[12:8] = writedata[12:8];
          end
        end
        RRS_FADDR_OFS: next_faddr = writedata[6:0];
        RRS_FDATA_OFS: f_we = 1'b1;
        RRS_STACK_OFS: begin
          // Push wraps like a circular stack; overflow is silent
          stk_we = 1'b1;
          next_sp = sp + SPW'(1);
        end
        default: next_faddr = next_faddr;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= RRS_ST_IDLE;
      w <= RRS_W_RST;
      carry <= RRS_C_RST;
      timeout_flag <= RRS_TIMEOUT_RST;
      power_down_flag <= RRS_PWRDN_RST;
      pc <= RRS_PC_RST;
      sp <= '0;
      faddr <= 7'h00;
      wdt_clear <= 1'b0;
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      w <= next_w;
      carry <= next_carry;
      timeout_flag <= next_timeout_flag;
      power_down_flag <= next_power_down_flag;
      pc <= next_pc;
      sp <= next_sp;
      faddr <= next_faddr;
      wdt_clear <= next_wdt_clear;
      ack <= next_ack;
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------
  // Storage arrays
  // ----------------------------------------
  // No reset on arrays: contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (stk_we) begin
      stack[stk_wa] <= stk_wd;
    end
    if (f_we) begin
      fmem[f_wa] <= f_wd;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic go;
  assign go = wr_take && address == RRS_CMD_OFS && state == RRS_ST_IDLE;

  ret_pop_pc_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_RETURN |=> pc == $past(stack_top_entry)
      && state == RRS_ST_RET2 ##1 state == RRS_ST_IDLE)
    else $error("return did not load pc in two cycles");
  ret_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_RETURN |=> $stable(carry) && $stable(timeout_flag)
      && $stable(power_down_flag))
    else $error("return changed a flag");
  ret_busy_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_RETURN |=> !(wr_take && address == RRS_CMD_OFS))
    else $error("command taken in second return cycle");
  rotl_result_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_ROTL && !cmd.dest_file
      |=> w == {$past(fsrc[6:0]), $past(carry)})
    else $error("left rotate result wrong");
  rotl_dest_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_ROTL && cmd.dest_file
      |=> $stable(w) && fmem[$past(cmd.faddr)] == {$past(fsrc[6:0]), $past(carry)})
    else $error("left rotate destination wrong");
  rotr_result_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_ROTR && !cmd.dest_file
      |=> w == {$past(carry), $past(fsrc[7:1])})
    else $error("right rotate result wrong");
  rotr_dest_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_ROTR && cmd.dest_file
      |=> $stable(w) && fmem[$past(cmd.faddr)] == {$past(carry), $past(fsrc[7:1])})
    else $error("right rotate destination wrong");
  rot_carry_a: assert property (@(posedge clk) disable iff (!resetn)
    go && (cmd.op == RRS_OP_ROTL || cmd.op == RRS_OP_ROTR)
      |=> carry == ($past(cmd.op) == RRS_OP_ROTL ? $past(fsrc[7]) : $past(fsrc[0]))
      && $stable(timeout_flag) && $stable(power_down_flag))
    else $error("rotate carry or flags wrong");
  sleep_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_SLEEP |=> !power_down_flag && timeout_flag)
    else $error("sleep flags wrong");
  wdt_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_SLEEP |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong");
  osc_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    go && cmd.op == RRS_OP_SLEEP |=> sleep_state && !osc_enable)
    else $error("sleep did not stop oscillator");
endmodule
`default_nettype wire

/* File: rrs_pkg.sv */
package rrs_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] RRS_CMD_OFS = 5'h00;
  localparam logic [4:0] RRS_W_OFS = 5'h04;
  localparam logic [4:0] RRS_STAT_OFS = 5'h08;
  localparam logic [4:0] RRS_PC_OFS = 5'h0c;
  localparam logic [4:0] RRS_FADDR_OFS = 5'h10;
  localparam logic [4:0] RRS_FDATA_OFS = 5'h14;
  localparam logic [4:0] RRS_STACK_OFS = 5'h18;
  localparam logic [4:0] RRS_WAKE_OFS = 5'h1c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RRS_CMD_OP_LSB = 0;
  localparam int RRS_CMD_F_LSB = 3;
  localparam int RRS_CMD_D_BIT = 10;
  localparam int RRS_ST_C_BIT = 0;
  localparam int RRS_ST_TIMEOUT_BIT = 1;
  localparam int RRS_ST_PWRDN_BIT = 2;
  localparam int RRS_ST_SLP_BIT = 3;
  localparam int RRS_ST_BUSY_BIT = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RRS_TIMEOUT_RST = 1'b1;
  localparam logic RRS_PWRDN_RST = 1'b1;
  localparam logic RRS_C_RST = 1'b0;
  localparam logic [7:0] RRS_W_RST = 8'h00;
  localparam logic [12:0] RRS_PC_RST = 13'h0000;
  // ----------------------------------------
  // Operations and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    RRS_OP_NOP = 3'h0,
    RRS_OP_RETURN = 3'h1,
    RRS_OP_ROTL = 3'h2,
    RRS_OP_ROTR = 3'h3,
    RRS_OP_SLEEP = 3'h4
  } rrs_op_t;
  typedef enum logic [2:0] {
    RRS_ST_IDLE = 3'b001,
    RRS_ST_RET2 = 3'b010,
    RRS_ST_SLEEP = 3'b100
  } rrs_state_t;
  typedef struct packed {
    logic dest_file;
    logic [6:0] faddr;
    rrs_op_t op;
  } rrs_cmd_t;
endpackage

/* File: tb_return_rotate_sleep_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_return_rotate_sleep_exec
  import rrs_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic wdt_clear;
  logic osc_enable;
  logic sleep_state;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  rrs_cmd_t cmd;
  logic [7:0] v, wv, res;
  logic [12:0] p1, p2;
  logic [6:0] fa;
  logic c, nc;
  int seed;

  always #5 clk = ~clk;

  rrs_exec DUT (
    .clk(clk),
    .resetn(resetn),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .wdt_clear(wdt_clear),
    .osc_enable(osc_enable),
    .sleep_state(sleep_state)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read data is loaded when waitrequest drops and held until the next read; checked at the edge that takes the read
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      check(readdata, exp_q.pop_front());
    end
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Avalon master
  // ----------------------------------------
  // Hold keeps write up so the next call's request starts right after this one
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d,
                           input logic [3:0] be = 4'hf, input bit hold = 1'b0);
    @(posedge clk);
    write <= 1'b1;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    if (!hold) begin
      write <= 1'b0;
    end
  endtask

  task automatic bus_read(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    read <= 1'b1;
    address <= a;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
  endtask

  function automatic logic [31:0] op_word(input rrs_op_t op, input logic [6:0] f,
                                          input logic d);
    rrs_cmd_t k;
    k.dest_file = d;
    k.faddr = f;
    k.op = op;
    return {21'h0, k};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = $urandom(46039);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus_read(RRS_STAT_OFS, 32'h06);
    check({30'h0, osc_enable, sleep_state}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wv = $urandom;
      c = $urandom;
      fa = $urandom;
      bus_write(RRS_FADDR_OFS, {25'h0, fa});
      bus_write(RRS_FDATA_OFS, {24'h0, v});
      bus_write(RRS_W_OFS, {24'h0, wv});
      bus_write(RRS_STAT_OFS, {31'h0, c});
      bus_write(RRS_CMD_OFS, op_word(i[1] ? RRS_OP_ROTL : RRS_OP_ROTR, fa, i[0]));
      res = i[1] ? {v[6:0], c} : {c, v[7:1]};
      nc = i[1] ? v[7] : v[0];
      bus_read(RRS_W_OFS, {24'h0, i[0] ? wv : res});
      bus_read(RRS_FDATA_OFS, {24'h0, i[0] ? res : v});
      bus_read(RRS_STAT_OFS, {31'h3, nc});
    end
    // Lane 0 off: write must not land
    bus_write(RRS_W_OFS, 32'h5a, 4'he);
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_NOP, fa, 1'b0));
    bus_read(RRS_W_OFS, {24'h0, wv});
    bus_read(RRS_WAKE_OFS, 32'h0);
    p1 = $urandom;
    p2 = $urandom;
    bus_write(RRS_STACK_OFS, {19'h0, p1});
    bus_write(RRS_STACK_OFS, {19'h0, p2});
    bus_write(RRS_STAT_OFS, 32'h1);
    // Held write puts the second return's request in the busy cycle
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_RETURN, 7'h0, 1'b0), 4'hf, 1'b1);
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_RETURN, 7'h0, 1'b0));
    bus_read(RRS_PC_OFS, {19'h0, p1});
    bus_write(RRS_STACK_OFS, {19'h0, p2});
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_RETURN, 7'h0, 1'b0));
    bus_read(RRS_PC_OFS, {19'h0, p2});
    bus_read(RRS_STAT_OFS, 32'h07);
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_SLEEP, 7'h0, 1'b0));
    #1;
    check({31'h0, wdt_clear}, 32'h1);
    check({30'h0, osc_enable, sleep_state}, 32'h1);
    @(posedge clk);
    #1;
    check({31'h0, wdt_clear}, 32'h0);
    bus_read(RRS_STAT_OFS, 32'h0b);
    bus_write(RRS_CMD_OFS, op_word(RRS_OP_ROTL, fa, 1'b0));
    bus_read(RRS_W_OFS, {24'h0, wv});
    bus_write(RRS_WAKE_OFS, 32'h1);
    #1;
    check({30'h0, osc_enable, sleep_state}, 32'h2);
    repeat (3) @(posedge clk);
    check(exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
